// file: actpr_pkg.sv
// constants and types shared by the configuration and test-pattern block
package actpr_pkg;

	// register offsets on the configuration port
	localparam logic [7:0] ADDR_SAMPLING = 8'h11;
	localparam logic [7:0] ADDR_FUSE     = 8'h13;
	localparam logic [7:0] ADDR_PAT_LOW  = 8'h14;
	localparam logic [7:0] ADDR_PAT_MID  = 8'h15;
	localparam logic [7:0] ADDR_PAT_HIGH = 8'h16;
	localparam logic [7:0] ADDR_FRAME    = 8'h19;

	// writable bits of each register; all other positions store and read zero
	localparam logic [7:0] MASK_SAMPLING = 8'h05;
	localparam logic [7:0] MASK_FUSE     = 8'h01;
	localparam logic [7:0] MASK_FULL     = 8'hFF;
	localparam logic [7:0] MASK_FRAME    = 8'h91;
	localparam logic [7:0] MASK_NONE     = 8'h00;

	// reset values
	localparam logic [7:0] RST_SAMPLING = 8'h00;
	localparam logic [7:0] RST_FUSE     = 8'h00;
	localparam logic [7:0] RST_PAT_LOW  = 8'h00;
	localparam logic [7:0] RST_PAT_MID  = 8'h00;
	localparam logic [7:0] RST_PAT_HIGH = 8'h00;
	localparam logic [7:0] RST_FRAME    = 8'h00;

	// field positions
	localparam int BIT_LOOP_PDN   = 2;
	localparam int BIT_NULLING    = 0;
	localparam int BIT_FUSE_LOAD  = 0;
	localparam int LSB_SEL_SECOND = 5;
	localparam int LSB_SEL_FIRST  = 2;
	localparam int BIT_FRAME_SRC  = 7;
	localparam int BIT_FRAME_HALF = 4;
	localparam int BIT_FRAME_STR  = 0;

	// widths
	localparam int PAT_W  = 18;
	localparam int SEL_W  = 3;
	localparam int NUM_CH = 2;
	localparam int HI_W   = 2;

	// ramp increments the host loads per native resolution
	localparam logic [17:0] RAMP_STEP_18B = 18'h00021;
	localparam logic [17:0] RAMP_STEP_16B = 18'h00024;
	localparam logic [17:0] RAMP_STEP_14B = 18'h00010;

	typedef enum logic [1:0] {
		VAR_SLOW = 2'b00,
		VAR_MID  = 2'b01,
		VAR_FAST = 2'b10
	} actpr_variant_t;

	typedef enum logic [2:0] {
		PAT_NORMAL = 3'b000,
		PAT_RAMP   = 3'b010,
		PAT_CONST  = 3'b011
	} actpr_pat_mode_t;

endpackage : actpr_pkg

// file: actpr_pat_if.sv
// pattern settings passed from the register bank to the pattern generator
`timescale 1ns/100ps
`default_nettype none
interface actpr_pat_if;
	logic [1:0][2:0] sel;
	logic [17:0]     value;

	modport cfg (output sel, output value);
	modport gen (input sel, input value);
endinterface : actpr_pat_if
`default_nettype wire

// file: actpr_pat_gen.sv
// per-channel test-pattern insertion ahead of the output bit mapper
`timescale 1ns/100ps
`default_nettype none
module actpr_pat_gen (
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	actpr_pat_if.gen                     pat,
	input  wire logic                    sample_en,
	input  wire logic [1:0][17:0]        conv_data,
	output logic      [1:0][17:0]        ch_data,
	output logic                         ch_valid
);
	import actpr_pkg::*;

	typedef struct packed {
		logic [1:0][17:0] ramp;
		logic [1:0][17:0] data;
		logic             vld;
	} actpr_gen_state_t;

	actpr_gen_state_t state_ff;
	actpr_gen_state_t nxt_state;
	logic [1:0][17:0] nxt_ramp_w;
	logic [1:0][17:0] nxt_data_w;

	function automatic actpr_pat_mode_t decode_mode(input logic [2:0] sel);
		actpr_pat_mode_t m;
		m = PAT_NORMAL;
		if (sel == PAT_RAMP) begin
			m = PAT_RAMP;
		end else if (sel == PAT_CONST) begin
			m = PAT_CONST;
		end
		return m;
	endfunction : decode_mode

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			always_comb begin
				nxt_ramp_w[ch] = state_ff.ramp[ch];
				nxt_data_w[ch] = state_ff.data[ch];
				if (sample_en) begin
					// ramp step add
					// ramp restarts from zero on each sample taken while the channel is out of ramp mode
					nxt_ramp_w[ch] = (decode_mode(pat.sel[ch]) == PAT_RAMP) ?
						PAT_W'(state_ff.ramp[ch] + pat.value) : '0;
					case (decode_mode(pat.sel[ch]))
						PAT_RAMP:  nxt_data_w[ch] = state_ff.ramp[ch];
						PAT_CONST: nxt_data_w[ch] = pat.value;
						default:   nxt_data_w[ch] = conv_data[ch];
					endcase
				end
			end
		end
	endgenerate

	always_comb begin
		nxt_state      = state_ff;
		nxt_state.ramp = nxt_ramp_w;
		nxt_state.data = nxt_data_w;
		nxt_state.vld  = sample_en;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign ch_data  = state_ff.data;
	assign ch_valid = state_ff.vld;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_const_output: assert property (
		sample_en && pat.sel[0] == PAT_CONST |=> ch_data[0] == $past(pat.value) && ch_valid)
		else $error("constant pattern not presented on first channel");

	a_ramp_step: assert property (
		sample_en && pat.sel[1] == PAT_RAMP ##1 sample_en && pat.sel[1] == PAT_RAMP
			&& $stable(pat.value)
		|=> ch_data[1] == PAT_W'($past(ch_data[1]) + pat.value))
		else $error("ramp did not advance by the programmed step");

	a_normal_pass: assert property (
		sample_en && pat.sel[1] == PAT_NORMAL |=> ch_data[1] == $past(conv_data[1]))
		else $error("normal mode did not pass converter data");

endmodule : actpr_pat_gen
`default_nettype wire

// file: actpr_regs.sv
// configuration register bank with test-pattern and frame-clock controls
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - loop off selects half-period sampling time
// - loop control acts only on fastest variant
// - offset nulling polarity depends on variant
// - load discards earlier configuration writes
// - 18-bit pattern value across three registers
// - ramp steps by the pattern value
// - second channel selector 000/010/011 coding
// - first channel selector same coding
// - patterns inserted before mapper, MSB aligned
// - frame source picks converter or downconverter
// - stretch spans frame over both channels
module actpr_regs #(
	parameter actpr_pkg::actpr_variant_t FAMILY_VARIANT = actpr_pkg::VAR_FAST
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic              reg_wr_en,
	input  wire logic              reg_rd_en,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wr_data,
	output logic      [7:0]        reg_rd_data,
	input  wire logic [7:0]        interface_setting,
	output logic      [7:0]        mapping_sel,
	output logic                   mapping_load_pulse,
	output logic                   sampling_loop_powerdown,
	output logic                   offset_nulling_enable,
	input  wire logic              sample_en,
	input  wire logic [1:0][17:0]  conv_data,
	output logic      [1:0][17:0]  ch_data,
	output logic                   ch_valid,
	input  wire logic              conv_frame_strobe,
	input  wire logic              digital_downconverter_frame_strobe,
	output logic                   frame_clock_source,
	output logic                   frame_clock_halving,
	output logic                   frame_clock_stretch,
	output logic                   frame_clk_out
);
	import actpr_pkg::*;

	typedef struct packed {
		logic [7:0] sampling;
		logic [7:0] fuse;
		logic [7:0] pat_low;
		logic [7:0] pat_mid;
		logic [7:0] pat_high;
		logic [7:0] frame;
		logic [7:0] rd_data;
		logic [7:0] mapping;
		logic       load;
		logic       frame_lvl;
	} actpr_regs_state_t;

	actpr_regs_state_t state_ff;
	actpr_regs_state_t nxt_state;
	logic [7:0]        wdata;
	logic              load_evt;
	logic              frame_evt;

	actpr_pat_if pat_bus ();

	// writable-bit mask per offset; zero marks an unmapped address
	function automatic logic [7:0] wr_mask(input logic [7:0] addr);
		logic [7:0] m;
		m = MASK_NONE;
		if (addr == ADDR_SAMPLING) begin
			m = MASK_SAMPLING;
		end else if (addr == ADDR_FUSE) begin
			m = MASK_FUSE;
		end else if (addr == ADDR_PAT_LOW || addr == ADDR_PAT_MID || addr == ADDR_PAT_HIGH) begin
			m = MASK_FULL;
		end else if (addr == ADDR_FRAME) begin
			m = MASK_FRAME;
		end
		return m;
	endfunction : wr_mask

	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == ADDR_SAMPLING) || (addr == ADDR_FUSE) || (addr == ADDR_PAT_LOW) ||
			(addr == ADDR_PAT_MID) || (addr == ADDR_PAT_HIGH) || (addr == ADDR_FRAME);
	endfunction : is_mapped

	assign wdata = reg_wr_data & wr_mask(reg_addr);

	// load on falling edge
	// the mapping only moves once the host returns the load bit to zero
	assign load_evt = reg_wr_en && reg_addr == ADDR_FUSE && state_ff.fuse[BIT_FUSE_LOAD]
		&& !wdata[BIT_FUSE_LOAD];

	assign frame_evt = state_ff.frame[BIT_FRAME_SRC] ? digital_downconverter_frame_strobe :
		conv_frame_strobe;

	always_comb begin
		nxt_state      = state_ff;
		nxt_state.load = 1'b0;
		if (reg_wr_en) begin
			if (reg_addr == ADDR_SAMPLING) begin
				nxt_state.sampling = wdata;
			end else if (reg_addr == ADDR_FUSE) begin
				nxt_state.fuse = wdata;
			end else if (reg_addr == ADDR_PAT_LOW) begin
				nxt_state.pat_low = wdata;
			end else if (reg_addr == ADDR_PAT_MID) begin
				nxt_state.pat_mid = wdata;
			end else if (reg_addr == ADDR_PAT_HIGH) begin
				nxt_state.pat_high = wdata;
			end else if (reg_addr == ADDR_FRAME) begin
				nxt_state.frame = wdata;
			end
		end
		// load clears configuration
		// earlier writes are lost, so the host must do this step first
		if (load_evt) begin
			nxt_state.sampling = RST_SAMPLING;
			nxt_state.pat_low  = RST_PAT_LOW;
			nxt_state.pat_mid  = RST_PAT_MID;
			nxt_state.pat_high = RST_PAT_HIGH;
			nxt_state.frame    = RST_FRAME;
			nxt_state.mapping  = interface_setting;
			nxt_state.load     = 1'b1;
		end
		if (reg_rd_en) begin
			nxt_state.rd_data = 8'h00;
			if (reg_addr == ADDR_SAMPLING) begin
				nxt_state.rd_data = state_ff.sampling;
			end else if (reg_addr == ADDR_FUSE) begin
				nxt_state.rd_data = state_ff.fuse;
			end else if (reg_addr == ADDR_PAT_LOW) begin
				nxt_state.rd_data = state_ff.pat_low;
			end else if (reg_addr == ADDR_PAT_MID) begin
				nxt_state.rd_data = state_ff.pat_mid;
			end else if (reg_addr == ADDR_PAT_HIGH) begin
				nxt_state.rd_data = state_ff.pat_high;
			end else if (reg_addr == ADDR_FRAME) begin
				nxt_state.rd_data = state_ff.frame;
			end
		end
		// stretch toggles per frame
		// stretched: level toggles so one frame covers both channel slots
		if (frame_evt) begin
			nxt_state.frame_lvl = state_ff.frame[BIT_FRAME_STR] ? !state_ff.frame_lvl : 1'b1;
		end else if (!state_ff.frame[BIT_FRAME_STR]) begin
			nxt_state.frame_lvl = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= '{sampling: RST_SAMPLING, fuse: RST_FUSE, pat_low: RST_PAT_LOW,
				pat_mid: RST_PAT_MID, pat_high: RST_PAT_HIGH, frame: RST_FRAME,
				rd_data: 8'h00, mapping: 8'h00, load: 1'b0, frame_lvl: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pat_bus.value = {state_ff.pat_high[HI_W-1:0], state_ff.pat_mid, state_ff.pat_low};
	assign pat_bus.sel[1] = state_ff.pat_high[LSB_SEL_SECOND +: SEL_W];
	assign pat_bus.sel[0] = state_ff.pat_high[LSB_SEL_FIRST +: SEL_W];

	actpr_pat_gen u_pat_gen (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.pat       (pat_bus.gen),
		.sample_en (sample_en),
		.conv_data (conv_data),
		.ch_data   (ch_data),
		.ch_valid  (ch_valid)
	);

	// only the fastest variant
	// 1 here means the delay loop is off and sampling lasts half the period
	assign sampling_loop_powerdown = (FAMILY_VARIANT == VAR_FAST) &&
		state_ff.sampling[BIT_LOOP_PDN];

	assign offset_nulling_enable = (FAMILY_VARIANT == VAR_FAST) ? state_ff.sampling[BIT_NULLING] :
		!state_ff.sampling[BIT_NULLING];

	assign reg_rd_data         = state_ff.rd_data;
	assign mapping_sel         = state_ff.mapping;
	assign mapping_load_pulse  = state_ff.load;
	assign frame_clock_source  = state_ff.frame[BIT_FRAME_SRC];
	assign frame_clock_halving = state_ff.frame[BIT_FRAME_HALF];
	assign frame_clock_stretch = state_ff.frame[BIT_FRAME_STR];
	assign frame_clk_out       = state_ff.frame_lvl;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_unmapped_read: assert property (
		reg_rd_en && !is_mapped(reg_addr) |=> reg_rd_data == 8'h00)
		else $error("unmapped read returned nonzero data");

	a_reserved_zero: assert property (
		(state_ff.sampling & ~MASK_SAMPLING) == 8'h00 && (state_ff.frame & ~MASK_FRAME) == 8'h00
		&& (state_ff.fuse & ~MASK_FUSE) == 8'h00)
		else $error("reserved bit held a value");

	a_fuse_load: assert property (
		reg_wr_en && reg_addr == ADDR_FUSE && reg_wr_data[0] ##1
		!(reg_wr_en && reg_addr == ADDR_FUSE) ##1
		reg_wr_en && reg_addr == ADDR_FUSE && !reg_wr_data[0]
		|=> mapping_load_pulse && mapping_sel == $past(interface_setting) ##1 !mapping_load_pulse)
		else $error("load pulse did not apply the interface mapping");

	a_load_clears: assert property (
		mapping_load_pulse |-> pat_bus.value == 18'h00000 && !sampling_loop_powerdown
		&& !frame_clock_source && !frame_clock_halving && !frame_clock_stretch)
		else $error("configuration survived the load");

	a_pat_value: assert property (
		reg_wr_en && reg_addr == ADDR_PAT_MID && !load_evt
		|=> pat_bus.value[15:8] == $past(reg_wr_data) && $stable(pat_bus.value[7:0]))
		else $error("middle byte of the pattern value misplaced");

	a_sel_fields: assert property (
		reg_wr_en && reg_addr == ADDR_PAT_HIGH
		|=> pat_bus.sel[0] == $past(reg_wr_data[4:2]) && pat_bus.sel[1] == $past(reg_wr_data[7:5]))
		else $error("channel selector fields misplaced");

	a_loop_pdn: assert property (
		reg_wr_en && reg_addr == ADDR_SAMPLING
		|=> sampling_loop_powerdown == ((FAMILY_VARIANT == VAR_FAST) && $past(reg_wr_data[2])))
		else $error("loop power-down output wrong for variant");

	a_nulling_pol: assert property (
		reg_wr_en && reg_addr == ADDR_SAMPLING
		|=> offset_nulling_enable == ($past(reg_wr_data[0]) ^ (FAMILY_VARIANT != VAR_FAST)))
		else $error("offset nulling polarity wrong");

	a_frame_src: assert property (
		!frame_clock_stretch && !digital_downconverter_frame_strobe && conv_frame_strobe
		|=> frame_clk_out == !$past(frame_clock_source))
		else $error("frame clock taken from the wrong source");

	a_frame_ddc: assert property (
		!frame_clock_stretch && frame_clock_source && digital_downconverter_frame_strobe |=> frame_clk_out)
		else $error("downconverter frame strobe not passed");

	a_frame_idle: assert property (
		!frame_clock_stretch && !conv_frame_strobe && !digital_downconverter_frame_strobe |=> !frame_clk_out)
		else $error("frame clock high without a strobe");

	a_stretch_toggle: assert property (
		frame_clock_stretch && (frame_clock_source ? digital_downconverter_frame_strobe : conv_frame_strobe)
		|=> frame_clk_out != $past(frame_clk_out))
		else $error("stretched frame clock did not toggle");

	a_stretch_hold: assert property (
		frame_clock_stretch && !conv_frame_strobe && !digital_downconverter_frame_strobe
		|=> $stable(frame_clk_out))
		else $error("stretched frame clock moved without a strobe");

	a_halving_out: assert property (
		reg_wr_en && reg_addr == ADDR_FRAME |=> frame_clock_halving == $past(reg_wr_data[BIT_FRAME_HALF]))
		else $error("halving bit not exported");

	a_rd_frame: assert property (
		reg_rd_en && reg_addr == ADDR_FRAME |=> reg_rd_data == $past({frame_clock_source, 2'b00,
			frame_clock_halving, 3'b000, frame_clock_stretch}))
		else $error("frame register read disagrees with its outputs");

	a_rd_sampling: assert property (
		reg_rd_en && reg_addr == ADDR_SAMPLING
		|=> (reg_rd_data & ~MASK_SAMPLING) == 8'h00
		&& reg_rd_data[BIT_NULLING] == ($past(offset_nulling_enable) ^ (FAMILY_VARIANT != VAR_FAST))
		&& (FAMILY_VARIANT != VAR_FAST || reg_rd_data[BIT_LOOP_PDN] == $past(sampling_loop_powerdown)))
		else $error("sampling register read disagrees with its outputs");

	a_rd_fuse: assert property (
		reg_rd_en && reg_addr == ADDR_FUSE |=> reg_rd_data[7:1] == 7'h00)
		else $error("load register read shows reserved bits");

	a_rd_low: assert property (
		reg_rd_en && reg_addr == ADDR_PAT_LOW |=> reg_rd_data == $past(pat_bus.value[7:0]))
		else $error("low pattern byte read wrong");

	a_rd_mid: assert property (
		reg_rd_en && reg_addr == ADDR_PAT_MID |=> reg_rd_data == $past(pat_bus.value[15:8]))
		else $error("middle pattern byte read wrong");

	a_rd_high: assert property (
		reg_rd_en && reg_addr == ADDR_PAT_HIGH
		|=> reg_rd_data == $past({pat_bus.sel[1], pat_bus.sel[0], pat_bus.value[17:16]}))
		else $error("selector register read wrong");

	a_rd_hold: assert property (
		!reg_rd_en |=> $stable(reg_rd_data))
		else $error("read data moved without a read");

	a_map_hold: assert property (
		!mapping_load_pulse |-> $stable(mapping_sel))
		else $error("mapping changed without a load");

	a_pulse_single: assert property (
		mapping_load_pulse |=> !mapping_load_pulse)
		else $error("load pulse longer than one cycle");

	a_valid_rise: assert property (
		sample_en |=> ch_valid)
		else $error("sample not marked valid");

	a_valid_fall: assert property (
		!sample_en |=> !ch_valid)
		else $error("valid without a sample");

endmodule : actpr_regs
`default_nettype wire

// file: actpr_host_model.sv
// host model that programs the register bank over its strobe port
`timescale 1ns/100ps
`default_nettype none
module actpr_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rd_data,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	output logic      [7:0] interface_setting
);
	import actpr_pkg::*;

	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		interface_setting = 8'h00;
	end

	// released lines show the inverse so stale data never passes for fresh
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wr_data <= ~d;
	endtask : wr

	// read data is registered at the taken edge and holds until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		@(negedge core_clk);
		d = reg_rd_data;
	endtask : rd

	task automatic load_map(input logic [7:0] iface);
		@(posedge core_clk);
		interface_setting <= iface;
		wr(ADDR_FUSE, 8'h01);
		wr(ADDR_FUSE, 8'h00);
	endtask : load_map
endmodule : actpr_host_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the configuration and test-pattern register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin errors++; \
	$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp); end end
module tb_top;
	import actpr_pkg::*;

	logic                core_clk;
	logic                rst_b;
	logic                reg_wr_en;
	logic                reg_rd_en;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wr_data;
	logic [7:0]          reg_rd_data;
	logic [7:0]          interface_setting;
	logic [7:0]          mapping_sel;
	logic                mapping_load_pulse;
	logic                sampling_loop_powerdown;
	logic                offset_nulling_enable;
	logic                sample_en;
	logic [1:0][17:0]    conv_data;
	logic [1:0][17:0]    ch_data;
	logic                ch_valid;
	logic                conv_frame_strobe;
	logic                digital_downconverter_frame_strobe;
	logic                frame_clock_source;
	logic                frame_clock_halving;
	logic                frame_clock_stretch;
	logic                frame_clk_out;
	logic                slow_pdn;
	logic                slow_null;
	int                  errors;
	int                  total_checks;
	logic [7:0]          addrs [6] = '{ADDR_SAMPLING, ADDR_FUSE, ADDR_PAT_LOW, ADDR_PAT_MID, ADDR_PAT_HIGH, ADDR_FRAME};
	logic [7:0]          masks [6] = '{MASK_SAMPLING, MASK_FUSE, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FRAME};
	logic [17:0]         steps [3] = '{RAMP_STEP_18B, RAMP_STEP_16B, RAMP_STEP_14B};

	actpr_regs #(.FAMILY_VARIANT(VAR_FAST)) u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.interface_setting(interface_setting), .mapping_sel(mapping_sel),
		.mapping_load_pulse(mapping_load_pulse), .sampling_loop_powerdown(sampling_loop_powerdown),
		.offset_nulling_enable(offset_nulling_enable), .sample_en(sample_en), .conv_data(conv_data),
		.ch_data(ch_data), .ch_valid(ch_valid), .conv_frame_strobe(conv_frame_strobe),
		.digital_downconverter_frame_strobe(digital_downconverter_frame_strobe),
		.frame_clock_source(frame_clock_source), .frame_clock_halving(frame_clock_halving),
		.frame_clock_stretch(frame_clock_stretch), .frame_clk_out(frame_clk_out)
	);

	// slower variant: loop control inert, nulling polarity inverted
	actpr_regs #(.FAMILY_VARIANT(VAR_SLOW)) u_dut_slow (
		.core_clk(core_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(),
		.interface_setting(interface_setting), .mapping_sel(), .mapping_load_pulse(),
		.sampling_loop_powerdown(slow_pdn), .offset_nulling_enable(slow_null), .sample_en(sample_en),
		.conv_data(conv_data), .ch_data(), .ch_valid(), .conv_frame_strobe(conv_frame_strobe),
		.digital_downconverter_frame_strobe(digital_downconverter_frame_strobe),
		.frame_clock_source(), .frame_clock_halving(), .frame_clock_stretch(), .frame_clk_out()
	);

	actpr_host_model u_host (
		.core_clk(core_clk), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .interface_setting(interface_setting)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	task automatic done(input string name);
		$display("test %s finished at %0t", name, $time);
	endtask : done

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		`CHK(d, e, "register read")
	endtask : rdchk

	task automatic smp(input logic [17:0] c0, input logic [17:0] c1);
		@(posedge core_clk);
		sample_en <= 1'b1;
		conv_data <= {c1, c0};
		@(posedge core_clk);
		sample_en <= 1'b0;
		@(negedge core_clk);
		`CHK(ch_valid, 1'b1, "sample valid")
	endtask : smp

	// pulse one frame strobe; returns mid-cycle after the edge that takes it
	task automatic strobe(input logic from_ddc);
		@(posedge core_clk);
		if (from_ddc) begin
			digital_downconverter_frame_strobe <= 1'b1;
		end else begin
			conv_frame_strobe <= 1'b1;
		end
		@(posedge core_clk);
		digital_downconverter_frame_strobe <= 1'b0;
		conv_frame_strobe <= 1'b0;
		@(negedge core_clk);
	endtask : strobe

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("[FAIL] %0t run did not finish in time", $time);
		final_report();
	end

	initial begin
		logic        lvl;
		logic [17:0] exp_v;
		rst_b = 1'b0;
		sample_en = 1'b0;
		conv_data = '0;
		conv_frame_strobe = 1'b0;
		digital_downconverter_frame_strobe = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) rdchk(addrs[i], 8'h00);
		`CHK(slow_null, 1'b1, "slow nulling at reset")
		done("reset values");
		for (int i = 0; i < 6; i++) begin
			u_host.wr(addrs[i], 8'hFF);
			rdchk(addrs[i], masks[i]);
		end
		`CHK(sampling_loop_powerdown, 1'b1, "loop off")
		`CHK(offset_nulling_enable, 1'b1, "nulling on")
		`CHK({frame_clock_source, frame_clock_halving, frame_clock_stretch}, 3'b111, "frame bits")
		`CHK({slow_pdn, slow_null}, 2'b00, "slow variant")
		u_host.wr(8'h12, 8'hFF);
		rdchk(8'h12, 8'h00);
		done("access");
		// the earlier writes act as configuration that the load must discard
		u_host.load_map(8'h5A);
		@(negedge core_clk);
		`CHK(mapping_load_pulse, 1'b1, "load pulse")
		`CHK(mapping_sel, 8'h5A, "mapping")
		@(negedge core_clk);
		`CHK(mapping_load_pulse, 1'b0, "pulse width")
		`CHK(sampling_loop_powerdown, 1'b0, "loop cleared")
		`CHK(offset_nulling_enable, 1'b0, "nulling off")
		`CHK(slow_null, 1'b1, "slow nulling after load")
		for (int i = 0; i < 6; i++) rdchk(addrs[i], 8'h00);
		done("load");
		u_host.wr(ADDR_PAT_LOW, 8'hCD);
		u_host.wr(ADDR_PAT_MID, 8'hAB);
		u_host.wr(ADDR_PAT_HIGH, {PAT_NORMAL, PAT_CONST, 2'b10});
		smp(18'h11111, 18'h22222);
		`CHK(ch_data[0], 18'h2ABCD, "const first")
		`CHK(ch_data[1], 18'h22222, "normal second")
		u_host.wr(ADDR_PAT_HIGH, {PAT_CONST, 3'b001, 2'b10});
		smp(18'h13579, 18'h2468A);
		`CHK(ch_data[0], 18'h13579, "unused code")
		`CHK(ch_data[1], 18'h2ABCD, "const second")
		done("constant");
		for (int j = 0; j < 3; j++) begin
			u_host.wr(ADDR_PAT_HIGH, 8'h00);
			smp(18'h00000, 18'h00000);
			u_host.wr(ADDR_PAT_LOW, steps[j][7:0]);
			u_host.wr(ADDR_PAT_MID, steps[j][15:8]);
			u_host.wr(ADDR_PAT_HIGH, {PAT_RAMP, PAT_RAMP, steps[j][17:16]});
			@(posedge core_clk);
			sample_en <= 1'b1;
			conv_data <= '1;
			// back-to-back samples so the ramp step assertion sees two in a row
			for (int k = 0; k < 3; k++) begin
				@(posedge core_clk);
				sample_en <= (k < 2);
				@(negedge core_clk);
				exp_v = steps[j] * 18'(k);
				`CHK(ch_valid, 1'b1, "ramp valid")
				`CHK(ch_data[0], exp_v, "ramp first")
				`CHK(ch_data[1], exp_v, "ramp second")
			end
		end
		done("ramp");
		u_host.wr(ADDR_FRAME, 8'h00);
		strobe(1'b0);
		`CHK(frame_clk_out, 1'b1, "converter frame")
		@(negedge core_clk);
		`CHK(frame_clk_out, 1'b0, "frame width")
		u_host.wr(ADDR_FRAME, 8'h80);
		strobe(1'b0);
		`CHK(frame_clk_out, 1'b0, "converter ignored")
		strobe(1'b1);
		`CHK(frame_clk_out, 1'b1, "downconverter frame")
		u_host.wr(ADDR_FRAME, 8'h81);
		@(negedge core_clk);
		lvl = frame_clk_out;
		strobe(1'b1);
		`CHK(frame_clk_out, ~lvl, "stretch toggle")
		repeat (2) @(negedge core_clk);
		`CHK(frame_clk_out, ~lvl, "stretch holds")
		strobe(1'b1);
		`CHK(frame_clk_out, lvl, "stretch back")
		done("frame clock");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
